// file: hdl/supply_status_timers.sv
// supply status delay timers: request debounce, output-good delays, trip
// filters, status pin drive options, address strap, wishbone registers
// assumes the six status pins are asynchronous and a classic wishbone master on clk_i
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "supply_timing_cfg.svh"

module supply_status_timers #(
  parameter int unsigned MS_CYC    = `MS_CYCLES,  // cycles per millisecond
  parameter int unsigned UV_CYC    = `UV_CYCLES,  // undervoltage filter cycles
  parameter logic [6:0]  ADDR_BASE = 7'h50        // arbitrary bus address base
) (
  input  wire logic        clk_i,                      // 25 MHz clock
  input  wire logic        rst_i,                      // sync reset, high
  input  wire logic        ce_i,                       // clock enable
  input  wire logic        cyc_i,                      // wishbone cycle
  input  wire logic        stb_i,                      // wishbone strobe
  input  wire logic        we_i,                       // wishbone write
  input  wire logic [7:0]  adr_i,                      // wishbone byte address
  input  wire logic [3:0]  sel_i,                      // wishbone byte lanes
  input  wire logic [31:0] dat_i,                      // wishbone write data
  output logic             ack_o,                      // wishbone ack
  output logic [31:0]      dat_o,                      // wishbone read data
  output logic             irq_o,                      // level interrupt
  input  wire logic        power_on_request_input_i,   // request pin, high = on
  input  wire logic        ov_cmp_i,                   // overvoltage comparator
  input  wire logic        uv_cmp_i,                   // undervoltage comparator
  input  wire logic        mains_good_flag_i,          // mains good level
  input  wire logic        strap_hi_i,                 // strap sensed high
  input  wire logic        strap_lo_i,                 // strap sensed low
  output logic             power_enable_output_o,      // pin level when driven
  output logic             power_enable_output_oe_n_o, // low while driving
  output logic             output_good_flag_o,         // pin level when driven
  output logic             output_good_flag_oe_n_o,    // low while driving
  output logic [6:0]       bus_address_o               // resolved bus address
);
  import supply_timing_pkg::*;

  top_state_t          q;        // registered state
  top_state_t          d;        // next state
  logic [2:0]          filt;     // filtered request, ov, uv
  logic [2:0]          filt_in;  // filter samples
  logic [`CNT_W-1:0]   lim [3];  // filter limits
  logic                req_in;   // request after function select
  logic                ov_en;    // overvoltage monitor armed
  logic                uv_en;    // undervoltage monitor armed
  logic                req_ok;   // request, mains good and no fault
  logic                trip;     // any filtered trip
  logic                good_en;  // output-good function selected
  logic                access;   // bus request not yet acked
  logic [31:0]         wword;    // byte-merged write word
  logic [31:0]         clr;      // write-one-to-clear bits
  logic [3:0]          ev;       // interrupt events
  logic [`CNT_W-1:0]   on_lim;   // on delay in cycles
  logic [`CNT_W-1:0]   warn_lim; // warning in cycles
  logic                pen_act;  // power enable pin active
  logic                good_act; // output good pin active

  // pick one of four millisecond figures and scale to cycles
  function automatic logic [`CNT_W-1:0] ms_sel(input logic [1:0] code,
                                               input int unsigned v0,
                                               input int unsigned v1,
                                               input int unsigned v2,
                                               input int unsigned v3);
    int unsigned ms;
    unique case (code)
      2'h0: ms = v0;
      2'h1: ms = v1;
      2'h2: ms = v2;
      2'h3: ms = v3;
    endcase
    ms_sel = `CNT_W'(ms * MS_CYC);
  endfunction

  // merge write data into an old word under the byte lanes
  function automatic logic [31:0] bmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
    bmerge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        bmerge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // function and mode decode from the control register
  always_comb begin
    req_in  = (q.ctrl[`F_RFN] inside {3'h0, 3'h1}) ? q.sync2[0] : 1'b1;
    good_en = q.ctrl[`F_GFN] inside {3'h0, 3'h1};
    ov_en   = q.ctrl[`F_MON] inside {`MON_OV_A, `MON_OV_B};
    uv_en   = q.ctrl[`F_MON] inside {`MON_UV_A, `MON_UV_B};
    filt_in = {q.sync2[2] & uv_en, q.sync2[1] & ov_en, req_in};
    // code 01 is the bypass, a zero limit passes at once
    lim[0]  = ms_sel(q.ctrl[`F_DEB], `DEB_00_MS, 0, `DEB_10_MS, `DEB_11_MS);
    lim[1]  = `CNT_W'(`OV_CYCLES);
    lim[2]  = `CNT_W'(UV_CYC);
    on_lim  = ms_sel(q.ctrl[`F_ON], `ON_00_MS, `ON_01_MS, `ON_10_MS, `ON_11_MS);
    warn_lim = ms_sel(q.ctrl[`F_WARN], `WARN_00_MS, 0, `WARN_10_MS, `WARN_11_MS);
  end

  // one restartable filter each for request, overvoltage, undervoltage
  for (genvar g = 0; g < 3; g++) begin : g_filt
    level_filter u_filt (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .sample_i (filt_in[g]),
      .limit_i  (lim[g]),
      .level_o  (filt[g])
    );
  end

  assign trip   = filt[1] | filt[2];
  assign req_ok = filt[0] & q.sync2[3] & ~q.fault;
  assign access = cyc_i & stb_i & ~q.ack;

  // next state of everything
  always_comb begin
    d = q;
    // pins pass two flops before use
    d.sync1 = {strap_lo_i, strap_hi_i, mains_good_flag_i, uv_cmp_i, ov_cmp_i,
               power_on_request_input_i};
    d.sync2 = q.sync1;

    // strap: low 00, floating 01, high 10
    if (q.sync2[4] && !q.sync2[5]) begin
      d.strap = 2'h2;
    end else if (q.sync2[5] && !q.sync2[4]) begin
      d.strap = 2'h0;
    end else begin
      d.strap = 2'h1;
    end
    d.addr = ADDR_BASE + {5'h0, q.strap};

    // a fault holds power off until the request is withdrawn
    if (!filt[0]) begin
      d.fault = 1'b0;
    end

    // power sequence
    unique case (q.st)
      S_OFF: begin
        d.power_enable_output  = 1'b0;
        d.good = 1'b0;
        if (req_ok && !trip) begin
          d.power_enable_output = 1'b1;
          d.tmr = '0;
          d.st  = S_WAIT;
        end
      end
      S_WAIT: begin
        // good rises only after the full on delay
        if (!req_ok) begin
          d.power_enable_output = 1'b0;
          d.st  = S_OFF;
        end else if (q.tmr >= on_lim - `CNT_W'h1) begin
          d.good = 1'b1;
          d.st   = S_GOOD;
        end else begin
          d.tmr = q.tmr + `CNT_W'h1;
        end
      end
      S_GOOD: begin
        // with a nonzero warning, good falls first so the load gets its warning
        if (!req_ok) begin
          d.good = 1'b0;
          d.tmr  = '0;
          if (warn_lim == '0) begin
            d.power_enable_output = 1'b0;
            d.st  = S_OFF;
          end else begin
            d.st = S_WARN;
          end
        end
      end
      S_WARN: begin
        if (q.tmr >= warn_lim - `CNT_W'h1) begin
          d.power_enable_output = 1'b0;
          d.st  = S_OFF;
        end else begin
          d.tmr = q.tmr + `CNT_W'h1;
        end
      end
    endcase

    // a filtered trip drops both outputs at once, overriding the warning
    if (trip && q.st != S_OFF) begin
      d.power_enable_output   = 1'b0;
      d.good  = 1'b0;
      d.fault = 1'b1;
      d.st    = S_OFF;
    end

    // logical state to pin: polarity then drive type
    pen_act    = d.power_enable_output ^ q.ctrl[`B_PEN_INV];
    good_act   = (d.good & good_en) ^ q.ctrl[`B_GOOD_INV];
    d.pen_pin  = q.ctrl[`B_PEN_PCH];
    d.pen_oe_n = ~pen_act;
    d.good_pin  = q.ctrl[`B_GOOD_PCH];
    d.good_oe_n = ~good_act;

    // events: good rise, good fall, ov trip, uv trip
    ev    = 4'h0;
    ev[0] = d.good & ~q.good;
    ev[1] = ~d.good & q.good;
    ev[2] = filt[1] & ~q.trip_ov;
    ev[3] = filt[2] & ~q.trip_uv;
    // trip history kept in the state word so the edge stays one cycle
    d.trip_ov = filt[1];
    d.trip_uv = filt[2];

    // wishbone slave: ack one cycle after the request, then drop
    wword = 32'h0;
    clr   = 32'h0;
    d.ack = access;
    if (access) begin
      d.rdat = 32'h0;
      unique case ({adr_i[7:2], 2'b00})
        `REG_CTRL: begin
          d.rdat = {13'h0, q.ctrl};
          if (we_i) begin
            wword  = bmerge({13'h0, q.ctrl}, dat_i, sel_i);
            d.ctrl = wword[`CTRL_W-1:0];
          end
        end
        `REG_STATUS: begin
          d.rdat = {17'h0, q.addr, q.strap, q.sync2[3], filt[2], filt[1],
                    q.good, q.power_enable_output, filt[0]};
        end
        `REG_INT_STAT: begin
          d.rdat = {28'h0, q.int_stat};
          if (we_i) begin
            clr = bmerge(32'h0, dat_i, sel_i);
          end
        end
        `REG_INT_MASK: begin
          d.rdat = {28'h0, q.int_mask};
          if (we_i) begin
            wword      = bmerge({28'h0, q.int_mask}, dat_i, sel_i);
            d.int_mask = wword[3:0];
          end
        end
        default: begin
          d.rdat = 32'h0; // unmapped reads zero, writes dropped
        end
      endcase
    end

    // set wins over a clear in the same cycle
    d.int_stat = (q.int_stat & ~clr[3:0]) | ev;
    d.irq      = |(d.int_stat & d.int_mask);
  end

  // single state register; a low enable freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q           <= '0;
      q.st        <= S_OFF;
      q.ctrl      <= `CTRL_RST;
      q.strap     <= 2'h1;
      q.pen_oe_n  <= 1'b1;
      q.good_oe_n <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // outputs straight from the register
  assign ack_o                      = q.ack;
  assign dat_o                      = q.rdat;
  assign irq_o                      = q.irq;
  assign power_enable_output_o      = q.pen_pin;
  assign power_enable_output_oe_n_o = q.pen_oe_n;
  assign output_good_flag_o         = q.good_pin;
  assign output_good_flag_oe_n_o    = q.good_oe_n;
  assign bus_address_o              = q.addr;

  // checks, all on clk_i with the sync reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_deb_bypass;
    ce_i && q.ctrl[`F_DEB] == 2'h1 && req_in != filt[0] |=> filt[0] == $past(req_in);
  endproperty
  a_deb_bypass: assert property (p_deb_bypass)
    else $error("request bypass did not pass at once");

  property p_good_after_wait;
    $rose(q.good) |-> $past(q.st) == S_WAIT && $past(q.tmr) >= $past(on_lim) - 1;
  endproperty
  a_good_after_wait: assert property (p_good_after_wait)
    else $error("output good rose before the on delay");

  property p_warn_holds_pen;
    q.st == S_WARN |-> q.power_enable_output && !q.good;
  endproperty
  a_warn_holds_pen: assert property (p_warn_holds_pen)
    else $error("warning without power enable held");

  property p_ov_armed;
    $rose(filt[1]) |-> $past(ov_en);
  endproperty
  a_ov_armed: assert property (p_ov_armed)
    else $error("overvoltage trip while not armed");

  property p_uv_armed;
    $rose(filt[2]) |-> $past(uv_en);
  endproperty
  a_uv_armed: assert property (p_uv_armed)
    else $error("undervoltage trip while not armed");

  property p_req_fn_off;
    ce_i && !(q.ctrl[`F_RFN] inside {3'h0, 3'h1}) && q.ctrl[`F_DEB] == 2'h1 |=> filt[0];
  endproperty
  a_req_fn_off: assert property (p_req_fn_off)
    else $error("forced request did not pass the bypass filter");

  property p_pen_drive;
    ce_i |=> power_enable_output_oe_n_o == !(q.power_enable_output ^ $past(q.ctrl[`B_PEN_INV]));
  endproperty
  a_pen_drive: assert property (p_pen_drive)
    else $error("power enable drive disagrees with polarity");

  property p_good_fn_off;
    ce_i && !good_en && !q.ctrl[`B_GOOD_INV] |=> output_good_flag_oe_n_o;
  endproperty
  a_good_fn_off: assert property (p_good_fn_off)
    else $error("output good driven with function off");

  property p_strap_high;
    ce_i && q.sync2[4] && !q.sync2[5] ##1 ce_i |=> bus_address_o == ADDR_BASE + 7'h2;
  endproperty
  a_strap_high: assert property (p_strap_high)
    else $error("high strap gave wrong address");

endmodule

// file: hdl/supply_timing_cfg.svh
// constants for the supply status delay timers: offsets, fields, resets, timing
// assumes a 25 MHz clock; included by bare name wherever a number is needed
`ifndef SUPPLY_TIMING_CFG_SVH
`define SUPPLY_TIMING_CFG_SVH

// register byte offsets on the wishbone slave
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_INT_STAT  8'h08
`define REG_INT_MASK  8'h0c

// control register fields
`define F_DEB         1:0
`define F_ON          3:2
`define F_WARN        5:4
`define F_MON         8:6
`define F_RFN         11:9
`define F_GFN         14:12
`define B_PEN_INV     15
`define B_PEN_PCH     16
`define B_GOOD_INV    17
`define B_GOOD_PCH    18
`define CTRL_W        19
`define CTRL_RST      19'h00000

// monitor mode codes that arm the trips
`define MON_OV_A      3'h2
`define MON_OV_B      3'h4
`define MON_UV_A      3'h3
`define MON_UV_B      3'h5

// timing figures as printed, then cycle counts
`define CLK_KHZ       25000
`define DEB_00_MS     80
`define DEB_10_MS     40
`define DEB_11_MS     160
`define ON_00_MS      400
`define ON_01_MS      200
`define ON_10_MS      800
`define ON_11_MS      1600
`define WARN_00_MS    2
`define WARN_10_MS    1
`define WARN_11_MS    4
`define OV_FILT_US    5
`define UV_FILT_US    300
`define MS_CYCLES     (`CLK_KHZ)
`define OV_CYCLES     ((`OV_FILT_US * `CLK_KHZ + 999) / 1000)
`define UV_CYCLES     ((`UV_FILT_US * `CLK_KHZ + 999) / 1000)
`define CNT_W         32

`endif

// file: hdl/supply_timing_pkg.sv
// types shared by the supply status delay timers
// assumes the cfg header for widths
`include "supply_timing_cfg.svh"

package supply_timing_pkg;

  // power sequence states, one-hot
  typedef enum logic [3:0] {
    S_OFF  = 4'b0001,
    S_WAIT = 4'b0010,
    S_GOOD = 4'b0100,
    S_WARN = 4'b1000
  } seq_t;

  // state of one restartable filter
  typedef struct packed {
    logic                lvl;
    logic [`CNT_W-1:0]   cnt;
  } filt_state_t;

  // whole state of the top block
  typedef struct packed {
    logic [5:0]          sync1;
    logic [5:0]          sync2;
    logic [`CTRL_W-1:0]  ctrl;
    logic [3:0]          int_stat;
    logic [3:0]          int_mask;
    logic                ack;
    logic [31:0]         rdat;
    seq_t                st;
    logic [`CNT_W-1:0]   tmr;
    logic                fault;
    logic                good;
    logic                power_enable_output;
    logic [1:0]          strap;
    logic [6:0]          addr;
    logic                pen_pin;
    logic                pen_oe_n;
    logic                good_pin;
    logic                good_oe_n;
    logic                irq;
    logic                trip_ov;
    logic                trip_uv;
  } top_state_t;

endpackage

// file: hdl/level_filter.sv
// restartable level filter: the output takes a new level only after the
// input has differed from it for limit_i consecutive enabled cycles
`timescale 1ns/1ps
`include "supply_timing_cfg.svh"

module level_filter (
  input  wire logic              clk_i,    // block clock
  input  wire logic              rst_i,    // sync reset, high
  input  wire logic              ce_i,     // clock enable
  input  wire logic              sample_i, // level to filter, same domain
  input  wire logic [`CNT_W-1:0] limit_i,  // cycles to accept, 0 = pass
  output logic                   level_o   // filtered level
);
  import supply_timing_pkg::*;

  filt_state_t q;  // registered state
  filt_state_t d;  // next state

  // count while the input disagrees, restart when it agrees again
  always_comb begin
    d = q;
    if (sample_i != q.lvl) begin
      if (limit_i == '0 || q.cnt >= limit_i - `CNT_W'h1) begin
        d.lvl = sample_i;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + `CNT_W'h1;
      end
    end else begin
      d.cnt = '0;
    end
  end

  // single register for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign level_o = q.lvl;

endmodule

// file: dv/host_model.sv
// host side model: drives the power request pin, resolves both status pins
// assumes open-drain status pins that rest at the pull level when released
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_i,       // block clock
  input  wire logic pen_i,       // power enable level when driven
  input  wire logic pen_oe_n_i,  // low while power enable driven
  input  wire logic good_i,      // output good level when driven
  input  wire logic good_oe_n_i, // low while output good driven
  input  wire logic inv_i,       // polarity setting in use
  input  wire logic pch_i,       // drive type in use, 1 = p-channel
  output logic      req_o,       // power request pin
  output logic      pen_true_o,  // power enable asserted by name
  output logic      good_true_o  // output good asserted by name
);
  logic pen_pin;  // wire level of power enable
  logic good_pin; // wire level of output good

  // released pin sits at the pull, opposite the driven level
  assign pen_pin = pen_oe_n_i ? ~pch_i : pen_i;
  assign good_pin = good_oe_n_i ? ~pch_i : good_i;
  // asserted state follows the name, not the level
  assign pen_true_o = (pen_pin == pch_i) ^ inv_i;
  assign good_true_o = (good_pin == pch_i) ^ inv_i;

  initial req_o = 1'b0;

  // steady request, changed just after an edge
  task automatic set_req(input logic v);
    req_o <= v;
  endtask

  // bouncing request: high, a short drop, then high for good
  task automatic bounce(input int hi, input int lo);
    req_o <= 1'b1;
    repeat (hi) @(posedge clk_i);
    req_o <= 1'b0;
    repeat (lo) @(posedge clk_i);
    req_o <= 1'b1;
  endtask
endmodule

// file: dv/tb_top.sv
// testbench for the supply status delay timers
// assumes a shortened millisecond (10 cycles) and a 20 cycle undervoltage filter
`timescale 1ns/1ps
`include "supply_timing_cfg.svh"
module tb_top;
  localparam int MS = 10;          // cycles per shortened millisecond
  localparam int UV = 20;          // undervoltage filter cycles
  localparam int OV = 125;         // overvoltage filter, fixed 5 us
  localparam logic [6:0] BASE = 7'h50; // arbitrary bus address base
  localparam int DEB[4] = '{80, 0, 40, 160};
  localparam int ON[4] = '{400, 200, 800, 1600};
  localparam int WRN[4] = '{2, 0, 1, 4};
  logic        clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel, lanes;
  logic [31:0] wdat, rdat, q;
  logic        req, ov, uv, mains, s_hi, s_lo, inv, pch, ce;
  logic        power_enable_output, pen_oe_n, good, good_oe_n, pen_t, good_t;
  logic [6:0]  addr;
  int          miscompares, num_checks, n;

  supply_status_timers #(.MS_CYC(MS), .UV_CYC(UV), .ADDR_BASE(BASE)) i_supply_status_timers (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .irq_o(irq),
    .power_on_request_input_i(req), .ov_cmp_i(ov), .uv_cmp_i(uv),
    .mains_good_flag_i(mains), .strap_hi_i(s_hi), .strap_lo_i(s_lo),
    .power_enable_output_o(power_enable_output), .power_enable_output_oe_n_o(pen_oe_n),
    .output_good_flag_o(good), .output_good_flag_oe_n_o(good_oe_n), .bus_address_o(addr));

  host_model i_host_model (
    .clk_i(clk_i), .pen_i(power_enable_output), .pen_oe_n_i(pen_oe_n), .good_i(good),
    .good_oe_n_i(good_oe_n), .inv_i(inv), .pch_i(pch), .req_o(req),
    .pen_true_o(pen_t), .good_true_o(good_t));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // value compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // cycle count must land inside a window
  task automatic chk_rng(input int c, input int lo, input int hi);
    num_checks++;
    if (c < lo || c > hi) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, c, lo, hi);
    end
  endtask

  // classic wishbone cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= lanes;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    if (k >= 50) chk(ack, 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // count edges until a decoded status reaches v
  task automatic wait_for(input logic g, input logic v, input int lim);
    n = 0;
    while (((g ? good_t : pen_t) !== v) && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) chk(g ? good_t : pen_t, v);
  endtask

  task automatic t_regs();
    wb(0, `REG_CTRL, 0); chk(q, 0);
    wb(0, `REG_INT_MASK, 0); chk(q, 0);
    chk({pen_oe_n, good_oe_n}, 2'b11);
    wb(1, 8'h10, 32'hffffffff); wb(0, 8'h10, 0); chk(q, 0);
    wb(1, `REG_CTRL, 32'hffffffff); wb(0, `REG_CTRL, 0); chk(q, 32'h7ffff);
    // only the enabled byte lane may change
    lanes = 4'h2;
    wb(1, `REG_CTRL, 0); wb(0, `REG_CTRL, 0); chk(q, 32'h700ff);
    lanes = 4'hf;
    wb(1, `REG_CTRL, 32'h15);
    wait_for(0, 0, 200);
    $display("test regs done");
  endtask

  task automatic t_strap();
    logic [1:0] pins[4] = '{2'b01, 2'b00, 2'b10, 2'b11}; // lo, float, hi, both
    int code[4] = '{0, 1, 2, 1};
    for (int k = 0; k < 4; k++) begin
      {s_hi, s_lo} <= pins[k];
      repeat (8) @(posedge clk_i);
      chk(addr, BASE + 7'(code[k]));
    end
    $display("test strap done");
  endtask

  task automatic t_debounce();
    int d;
    for (int i = 0; i < 4; i++) begin
      d = DEB[i] * MS;
      wb(1, `REG_CTRL, 32'h14 | i);
      // first code also bounces: the count must start over
      if (i == 0) i_host_model.bounce(d / 2, 10);
      else i_host_model.set_req(1'b1);
      wait_for(0, 1, d + 20);
      chk_rng(n, d, d + 6);
      i_host_model.set_req(1'b0);
      wait_for(0, 0, d + 20);
    end
    $display("test debounce done");
  endtask

  task automatic t_sequence();
    int on, w;
    for (int i = 0; i < 4; i++) begin
      on = ON[i] * MS;
      w = WRN[i] * MS;
      wb(1, `REG_CTRL, 32'h1 | (i << 2) | (i << 4));
      i_host_model.set_req(1'b1);
      wait_for(0, 1, 20);
      // a low enable must hold the on delay still
      ce <= 1'b0;
      repeat (50) @(posedge clk_i);
      ce <= 1'b1;
      wait_for(1, 1, on + 20);
      chk_rng(n, on - 2, on + 4);
      wb(0, `REG_STATUS, 0); chk(q[14:0], 15'h5167);
      i_host_model.set_req(1'b0);
      wait_for(1, 0, 20);
      wait_for(0, 0, w + 20);
      chk_rng(n, (w > 2) ? w - 2 : 0, w + 3);
    end
    $display("test sequence done");
  endtask

  task automatic t_trips();
    int md[4] = '{2, 4, 3, 5};
    int lim;
    logic isov;
    for (int i = 0; i < 4; i++) begin
      isov = (md[i] == 2 || md[i] == 4);
      lim = isov ? OV : UV;
      wb(1, `REG_CTRL, 32'h15 | (md[i] << 6));
      i_host_model.set_req(1'b1);
      wait_for(1, 1, 2100);
      // short glitch must be filtered out
      if (isov) ov <= 1'b1; else uv <= 1'b1;
      repeat (lim / 2) @(posedge clk_i);
      ov <= 1'b0; uv <= 1'b0;
      repeat (lim + 10) @(posedge clk_i);
      chk(good_t, 1'b1);
      if (isov) ov <= 1'b1; else uv <= 1'b1;
      wait_for(1, 0, lim + 20);
      chk_rng(n, lim, lim + 6);
      chk(pen_t, 1'b0);
      ov <= 1'b0; uv <= 1'b0;
      repeat (lim + 20) @(posedge clk_i);
      chk(irq, 1'b0);
      wb(1, `REG_INT_MASK, 32'hc);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      wb(0, `REG_INT_STAT, 0); chk(q[3:0], isov ? 4'h7 : 4'hb);
      wb(1, `REG_INT_STAT, 32'hf);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      wb(1, `REG_INT_MASK, 0);
      i_host_model.set_req(1'b0);
      repeat (20) @(posedge clk_i);
    end
    $display("test trips done");
  endtask

  task automatic t_polarity();
    for (int c = 0; c < 4; c++) begin
      inv <= c[0];
      pch <= c[1];
      wb(1, `REG_CTRL, 32'h15 | (c[0] << 15) | (c[1] << 16) | (c[0] << 17) | (c[1] << 18));
      repeat (4) @(posedge clk_i);
      chk({pen_t, good_t}, 2'b00);
      i_host_model.set_req(1'b1);
      wait_for(1, 1, 2100);
      chk(pen_t, 1'b1);
      chk(good_oe_n, c[0]);
      i_host_model.set_req(1'b0);
      wait_for(0, 0, 20);
    end
    inv <= 1'b0;
    pch <= 1'b0;
    wb(1, `REG_CTRL, 32'h15);
    $display("test polarity done");
  endtask

  task automatic t_functions();
    wb(1, `REG_CTRL, 32'h15 | (1 << 9));
    repeat (10) @(posedge clk_i);
    chk(pen_t, 1'b0);
    // mains down must hold power off despite a request
    mains <= 1'b0;
    i_host_model.set_req(1'b1);
    repeat (10) @(posedge clk_i);
    chk(pen_t, 1'b0);
    mains <= 1'b1;
    wait_for(0, 1, 20); chk_rng(n, 0, 6);
    i_host_model.set_req(1'b0);
    wait_for(0, 0, 20);
    // other function: request counts as true with the pin low
    wb(1, `REG_CTRL, 32'h15 | (2 << 9));
    wait_for(0, 1, 20); chk_rng(n, 0, 6);
    i_host_model.set_req(1'b1);
    wb(1, `REG_CTRL, 32'h15 | (2 << 12));
    repeat (2100) @(posedge clk_i);
    chk({pen_t, good_t}, 2'b10);
    wb(1, `REG_CTRL, 32'h15 | (1 << 12));
    wait_for(1, 1, 2100);
    i_host_model.set_req(1'b0);
    wait_for(0, 0, 20);
    $display("test functions done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    {cyc, stb, we, ov, uv, s_hi, s_lo, inv, pch} = '0;
    adr = '0; sel = '0; wdat = '0; mains = 1'b1; rst_i = 1'b1;
    ce = 1'b1;
    lanes = 4'hf;
    miscompares = 0; num_checks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_strap();
    t_debounce();
    t_sequence();
    t_trips();
    t_polarity();
    t_functions();
    summarize();
  end

  // watchdog, well past the expected run of some 60k cycles
  initial begin
    #4000000;
    miscompares++;
    summarize();
  end
endmodule
